/* apwa_ctrl.sv */
// host controller driving a 256K x 16 asynchronous pseudo static memory
`timescale 1ns/1ns
// Notes on behaviour
// - read needs selects, output low, write high
// - selects held long enough before write end
// - address stable long before write end
// - address stable no later than write start
// - address unchanged until write ends
// - write spans overlap of all strobes
module apwa_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // user request
  input wire apwa_pkg::apwa_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  // user answer
  output logic [apwa_pkg::DATA_W-1:0] rdata,
  output logic rdata_valid,
  output logic write_done,
  // memory pins
  output logic [apwa_pkg::ADDR_W-1:0] mem_addr,
  output apwa_pkg::apwa_strobe_t mem_strobe,
  input wire logic [apwa_pkg::DATA_W-1:0] mem_data_in,
  output logic [apwa_pkg::DATA_W-1:0] mem_data_out,
  output logic mem_data_oe
);
  import apwa_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_READ = 5'b00010,
    ST_WSETUP = 5'b00100,
    ST_WRITE = 5'b01000,
    ST_GAP = 5'b10000
  } apwa_state_t;

  // every phase lasts at least the slowest grade's figure, so one build serves all grades;
  // the price is a slower bus on the faster parts
  //   read:  take, two strobe cycles with data taken as they rise, two gap cycles
  //   write: take, one address setup cycle, two cycles of write strobe low, two gap cycles

  // lane pins follow the request on the cycle it is taken and the latched mask after it;
  // the result is inverted because both lane pins are active low
  function automatic logic [1:0] lane_pins(input logic from_req, input logic [1:0] req_lanes,
      input logic [1:0] held_lanes);
    logic [1:0] pick;
    pick = from_req ? req_lanes : held_lanes;
    return ~pick;
  endfunction

  apwa_state_t state;
  apwa_state_t next_state;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic tmr_done;
  logic [1:0] lanes;

  apwa_timer #(.W(CNT_W)) u_timer (
    .core_clk(core_clk),
    .reset(reset),
    .load(tmr_load),
    .value(tmr_value),
    .done(tmr_done)
  );

  // an empty lane mask would leave the device in standby, so it is refused
  wire logic take = req_valid && req_ready && (req.lane_en != 2'b00);
  // ready is only high in idle, so this merely guards against a stray ready
  wire logic accept = take && (state == ST_IDLE);

  always_comb begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_value = CNT_RESET;
    unique case (state)
      ST_IDLE: begin
        if (take) begin
          tmr_load = 1'b1;
          if (req.write) begin
            // address settles one cycle before the write strobe falls
            next_state = ST_WSETUP;
            tmr_value = CNT_RESET;
          end else begin
            next_state = ST_READ;
            tmr_value = CNT_W'(READ_WAIT_CYCLES);
          end
        end
      end
      ST_READ: begin
        if (tmr_done) begin
          next_state = ST_GAP;
          tmr_load = 1'b1;
          tmr_value = CNT_W'(GAP_CYCLES);
        end
      end
      ST_WSETUP: begin
        next_state = ST_WRITE;
        tmr_load = 1'b1;
        tmr_value = CNT_W'(WRITE_LOW_CYCLES);
      end
      ST_WRITE: begin
        if (tmr_done) begin
          next_state = ST_GAP;
          tmr_load = 1'b1;
          tmr_value = CNT_W'(GAP_CYCLES);
        end
      end
      ST_GAP: begin
        if (tmr_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      req_ready <= 1'b1;
    end else begin
      req_ready <= (next_state == ST_IDLE);
    end
  end

  // address latches on acceptance and stays until the next one, past the strobes' rise
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_addr <= '0;
    end else if (accept) begin
      mem_addr <= req.addr;
    end
  end

  // write data stands from the setup cycle, well ahead of the write's end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_data_out <= '0;
    end else if (accept) begin
      mem_data_out <= req.wdata;
    end
  end

  // lane mask kept for the strobes and for masking the read data
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lanes <= 2'b00;
    end else if (accept) begin
      lanes <= req.lane_en;
    end
  end

  // strobes: read holds output low and write high; write is the overlap of all strobes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_strobe <= STROBE_IDLE;
    end else begin
      mem_strobe <= STROBE_IDLE;
      if (next_state == ST_READ) begin
        mem_strobe.select_low_active <= 1'b0;
        mem_strobe.select_high_active <= 1'b1;
        mem_strobe.output_n <= 1'b0;
        {mem_strobe.upper_lane_enable_n, mem_strobe.lower_lane_enable_n} <=
          lane_pins(state == ST_IDLE, req.lane_en, lanes);
      end else if (next_state == ST_WSETUP || next_state == ST_WRITE) begin
        mem_strobe.select_low_active <= 1'b0;
        mem_strobe.select_high_active <= 1'b1;
        mem_strobe.write_n <= (next_state != ST_WRITE);
        {mem_strobe.upper_lane_enable_n, mem_strobe.lower_lane_enable_n} <=
          lane_pins(state == ST_IDLE, req.lane_en, lanes);
      end
    end
  end

  // host drives data only while write strobe is low, when device drivers are off
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_data_oe <= 1'b0;
    end else begin
      mem_data_oe <= (next_state == ST_WRITE);
    end
  end

  // data sampled at the last read cycle, well inside the device hold window
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata <= '0;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= 1'b0;
      if (state == ST_READ && tmr_done) begin
        rdata_valid <= 1'b1;
        rdata[7:0] <= lanes[0] ? mem_data_in[7:0] : 8'h00;
        rdata[15:8] <= lanes[1] ? mem_data_in[15:8] : 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      write_done <= 1'b0;
    end else begin
      write_done <= (state == ST_WRITE) && tmr_done;
    end
  end
endmodule // apwa_ctrl

/* apwa_pkg.sv */
// shared constants and carrier types for the asynchronous pseudo static memory controller
package apwa_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 100;
  // slowest grade figures, so one build serves every grade
  localparam int ADDRESS_ACCESS_TIME_NS = 70;
  localparam int OUTPUT_STROBE_ACCESS_TIME_NS = 35;
  localparam int ADDRESS_CHANGE_DATA_HOLD_NS = 10;
  localparam int SELECT_TO_WRITE_END_NS = 60;
  localparam int ADDRESS_SETUP_WRITE_END_NS = 55;
  localparam int WRITE_PULSE_NS = 45;
  localparam int DATA_SETUP_WRITE_END_NS = 25;
  localparam int CYCLE_TIME_NS = 70;
  localparam int ADDRESS_SETUP_WRITE_START_NS = 0;
  localparam int ADDRESS_HOLD_WRITE_END_NS = 0;
  // least times round up; read access is a longest time of the device, so waiting
  // for it means rounding up as well
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int READ_WAIT_CYCLES = ns_to_cycles(ADDRESS_ACCESS_TIME_NS);
  localparam int WRITE_LOW_CYCLES = ns_to_cycles(SELECT_TO_WRITE_END_NS);
  localparam int GAP_CYCLES = ns_to_cycles(CYCLE_TIME_NS);
  localparam int CNT_W = 4;
  localparam logic [3:0] CNT_RESET = 4'h0;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] lane_en;
  } apwa_req_t;

  typedef struct packed {
    logic select_low_active;
    logic select_high_active;
    logic write_n;
    logic output_n;
    logic upper_lane_enable_n;
    logic lower_lane_enable_n;
  } apwa_strobe_t;

  localparam apwa_strobe_t STROBE_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage

/* apwa_timer.sv */
// down counter that times the strobe and gap phases of each bus cycle; the write setup cycle is fixed by the controller
`timescale 1ns/1ns
module apwa_timer #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // load and status
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] count;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end

  // done must not look at load: the controller derives load from done, which would close a loop
  assign done = (count == '0);
endmodule // apwa_timer

/* apwa_mem_model.sv */
// behavioural model of the 256K x 16 pseudo static memory
`timescale 1ns/1ns
module apwa_mem_model (
  // pins from the controller
  input wire logic [apwa_pkg::ADDR_W-1:0] mem_addr,
  input wire apwa_pkg::apwa_strobe_t mem_strobe,
  input wire logic [apwa_pkg::DATA_W-1:0] mem_data_out,
  input wire logic mem_data_oe,
  // data back to the controller
  output logic [apwa_pkg::DATA_W-1:0] mem_data_in
);
  import apwa_pkg::*;
  logic [15:0] word [0:262143];
  logic sel, rd, wr;
  logic [18:0] key, key_d, key_h;
  logic [17:0] wadr;
  logic [15:0] w, m, shown, last, wlat, wm;
  assign sel = !mem_strobe.select_low_active && mem_strobe.select_high_active
    && !(mem_strobe.upper_lane_enable_n && mem_strobe.lower_lane_enable_n);
  assign wr = sel && !mem_strobe.write_n;
  assign rd = sel && mem_strobe.write_n && !mem_strobe.output_n;
  assign m = {{8{!mem_strobe.upper_lane_enable_n}}, {8{!mem_strobe.lower_lane_enable_n}}};
  assign w = word[mem_addr];
  // an undriven bus shows the inverse, so a missing enable corrupts the write; the word
  // is stored as the write ends, so the stored value never feeds back into the bus
  always @* if (wr) begin
    wadr = mem_addr;
    wm = m;
    wlat = mem_data_oe ? mem_data_out : ~w;
  end
  always @(negedge wr) word[wadr] = (word[wadr] & ~wm) | (wlat & wm);
  // inertial delay: data only valid once address and read held for the access time
  assign key = {rd, mem_addr};
  assign #ADDRESS_ACCESS_TIME_NS key_d = key;
  // floating lanes show the inverse of the stored byte
  assign shown = (w & m) | (~w & ~m);
  // the last good data lingers for the hold time after any address or strobe change
  assign #ADDRESS_CHANGE_DATA_HOLD_NS key_h = key;
  always @* if (rd && key_d === key) last = shown;
  assign mem_data_in = (rd && key_d === key) ? shown : (key_h !== key) ? last : ~w;
endmodule // apwa_mem_model

/* apwa_ctrl_props.sv */
// concurrent checks on the controller's ports
`timescale 1ns/1ns
module apwa_ctrl_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // user side
  input wire apwa_pkg::apwa_req_t req,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rdata_valid,
  input wire logic write_done,
  // memory pins
  input wire logic [apwa_pkg::ADDR_W-1:0] mem_addr,
  input wire apwa_pkg::apwa_strobe_t mem_strobe,
  input wire logic mem_data_oe
);
  import apwa_pkg::*;
  logic sel;
  assign sel = !mem_strobe.select_low_active && mem_strobe.select_high_active;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_read_strobes: assert property (!mem_strobe.output_n |-> sel && mem_strobe.write_n)
    else $error("output strobe low outside a read");
  a_drive_in_write: assert property (mem_data_oe |-> !mem_strobe.write_n && mem_strobe.output_n)
    else $error("host drives data outside a write");
  a_select_before_end: assert property ($rose(mem_strobe.write_n) |-> $past(sel) && $past(sel, 2))
    else $error("selects too short before write end");
  a_addr_held_write: assert property (!$past(mem_strobe.write_n) |-> $stable(mem_addr))
    else $error("address moved during write");
  a_addr_set_start: assert property ($fell(mem_strobe.write_n) |-> $stable(mem_addr) && sel)
    else $error("address not set at write start");
  a_write_lanes: assert property (!mem_strobe.write_n |->
    sel && !(mem_strobe.upper_lane_enable_n && mem_strobe.lower_lane_enable_n))
    else $error("write without select or lane");
  a_cycle_gap: assert property ($rose(mem_strobe.select_low_active) |=> mem_strobe.select_low_active)
    else $error("cycles too close");
  a_read_answer: assert property ($fell(mem_strobe.output_n) |-> ##[1:2] rdata_valid)
    else $error("read answer late");
  a_read_wait: assert property (rdata_valid |-> !$past(mem_strobe.output_n))
    else $error("read answer without output strobe");
  a_write_answer: assert property (write_done |-> !$past(mem_strobe.write_n, 2))
    else $error("write done without write strobe");
  a_refused_lane: assert property (req_valid && req_ready && req.lane_en == 2'b00 |=>
    req_ready && mem_strobe == STROBE_IDLE)
    else $error("empty lane mask not refused");
endmodule // apwa_ctrl_props
bind apwa_ctrl apwa_ctrl_props apwa_ctrl_props_i (.core_clk(core_clk), .reset(reset), .req(req),
  .req_valid(req_valid), .req_ready(req_ready), .rdata_valid(rdata_valid),
  .write_done(write_done), .mem_addr(mem_addr), .mem_strobe(mem_strobe), .mem_data_oe(mem_data_oe));

/* tb_top.sv */
// self-checking bench for the memory controller against the memory model
`timescale 1ns/1ns
module tb_top;
  import apwa_pkg::*;
  logic core_clk = 0, reset = 1, req_valid = 0, req_ready, rdata_valid, write_done, mem_data_oe;
  apwa_req_t req = '0;
  apwa_strobe_t mem_strobe;
  logic [17:0] mem_addr;
  logic [15:0] rdata, mem_data_in, mem_data_out, q;
  logic [15:0] shadow [0:262143];
  logic [17:0] al [$];
  logic [1:0] l;
  int n_fail = 0, n_tests = 0;
  always #50 core_clk = ~core_clk;
  apwa_ctrl apwa_ctrl_i (.core_clk(core_clk), .reset(reset), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid), .write_done(write_done),
    .mem_addr(mem_addr), .mem_strobe(mem_strobe), .mem_data_in(mem_data_in),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));
  apwa_mem_model apwa_mem_model_i (.mem_addr(mem_addr), .mem_strobe(mem_strobe),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in));
  function automatic logic [15:0] lm(input logic [1:0] x);
    return {{8{x[1]}}, {8{x[0]}}};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // waits on ready, so calls may follow each other with no gap
  task automatic xfer(input logic w, input logic [17:0] ad, input logic [15:0] d, input logic [1:0] ln);
    int k;
    req = '{w, ad, d, ln};
    req_valid = 1;
    for (k = 0; req_ready !== 1'b1 && k < 9; k++) @(posedge core_clk) #1;
    @(posedge core_clk) #1 req_valid = 0;
    for (k = 0; rdata_valid !== 1'b1 && write_done !== 1'b1 && k < 9; k++) @(posedge core_clk) #1;
    chk("answer", 16'h0001, 16'(k < 9));
    if (w) shadow[ad] = (shadow[ad] & ~lm(ln)) | (d & lm(ln));
    q = rdata;
  endtask
  initial begin
    #200_000; // roughly five times the expected run
    n_fail++;
    wrap_up();
  end
  initial begin
    void'($urandom(38966));
    repeat (12) @(posedge core_clk);
    #1 reset = 0;
    chk("reset strobes", 16'(STROBE_IDLE), 16'(mem_strobe));
    al = '{18'h0_0000, 18'h3_ffff};
    repeat (14) al.push_back(18'($urandom));
    foreach (al[i]) xfer(1'b1, al[i], 16'($urandom), 2'b11);
    foreach (al[i]) begin
      xfer(1'b0, al[i], 16'h0000, 2'b11);
      chk("word read", shadow[al[i]], q);
    end
    $display("test full words done");
    foreach (al[i]) begin
      xfer(1'b1, al[i], 16'($urandom), 2'($urandom_range(1, 3)));
      l = 2'($urandom_range(1, 3));
      xfer(1'b0, al[i], 16'h0000, l);
      chk("lane read", shadow[al[i]] & lm(l), q);
    end
    $display("test byte lanes done");
    req = '{1'b1, 18'h0_0005, 16'ha5a5, 2'b00};
    req_valid = 1;
    repeat (5) begin
      @(posedge core_clk) #1;
      chk("refused", 16'(STROBE_IDLE), 16'({write_done, rdata_valid, mem_strobe}));
    end
    $display("test refused mask done");
    req = '{1'b1, 18'h0_0005, 16'h1234, 2'b11};
    repeat (2) @(posedge core_clk) #1;
    reset = 1;
    req_valid = 0;
    #1 chk("reset in write", 16'(STROBE_IDLE), 16'({mem_data_oe, mem_strobe}));
    @(posedge core_clk) #1 reset = 0;
    xfer(1'b0, al[0], 16'h0000, 2'b11);
    chk("after reset", shadow[al[0]], q);
    $display("test mid reset done");
    wrap_up();
  end
endmodule // tb_top
